// ---- adc_cfg_pkg.sv ----
package adc_cfg_pkg;

    // ----------------------------------------------------------------
    // Register map (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [7:0] CTRL_OFF      = 8'h00;
    localparam logic [7:0] REF_CLK_OFF   = 8'h04;
    localparam logic [7:0] MUX_OFF       = 8'h08;
    localparam logic [7:0] SCAN_SEL_OFF  = 8'h0c;
    localparam logic [7:0] CTU_EN_OFF    = 8'h10;
    localparam logic [7:0] ANSEL_OFF     = 8'h14;
    localparam logic [7:0] DIR_OFF       = 8'h18;
    localparam logic [7:0] PORT_OFF      = 8'h1c;
    localparam logic [7:0] STATUS_OFF    = 8'h20;
    localparam logic [7:0] PIN_OUT_OFF   = 8'h24;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    // CTRL
    localparam int ENABLE_BIT     = 7;
    localparam int RES_BIT        = 3;
    localparam int ALT_BIT        = 0;
    localparam int SCAN_BIT       = 1;
    localparam int SMPI_LSB       = 8;   // samples per interrupt - 1, 5 bits
    localparam int ISRC_LSB       = 16;  // internal source requests, 3 bits
    // REF_CLK
    localparam int PREF_LSB       = 0;   // 2 bits
    localparam int NREF_BIT       = 2;
    localparam int PRESCALE_LSB   = 8;   // 6 bits
    localparam int RC_BIT         = 15;
    // MUX
    localparam int A_POS_LSB      = 0;
    localparam int A_NEG_LSB      = 5;
    localparam int B_POS_LSB      = 8;
    localparam int B_NEG_LSB      = 13;

    // ----------------------------------------------------------------
    // Widths, reset values and timing
    // ----------------------------------------------------------------
    localparam int          NUM_CH       = 32;
    localparam int          PIN_W        = 16;
    localparam logic [15:0] ANSEL_RESET  = 16'hffff;
    localparam logic [15:0] DIR_RESET    = 16'hffff;
    localparam logic [3:0]  TAD_12BIT    = 4'd14;
    localparam logic [3:0]  TAD_10BIT    = 4'd12;
    localparam logic [31:0] UNMAPPED_RD  = 32'h0000_0000;

    typedef enum logic [1:0] {
        PREF_AVDD, PREF_EXT, PREF_BANDGAP, PREF_RSVD
    } pos_ref_t;

    typedef struct packed {
        logic [4:0] pos;
        logic [2:0] neg;
        logic       mux_b;
    } input_sel_t;

    typedef struct packed {
        logic     pos_ext;
        logic     pos_bandgap;
        logic     neg_ext;
    } ref_sel_t;

endpackage

// ---- adc_cfg_regs.sv ----
`timescale 1ns/1ps

// Small register store for the channel mask words; read data registered.
module adc_cfg_regs
(
    // Clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // Write port
    input  wire logic        wr_en,
    input  wire logic [2:0]  wr_idx,
    input  wire logic [31:0] wr_data,
    // Read port
    input  wire logic [2:0]  rd_idx,
    output logic      [31:0] rd_data
);
    logic [31:0] mem_q [0:7];

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            for (int i = 0; i < 8; i++)
                mem_q[i] <= 32'h0000_0000;
        end
        else if (wr_en)
        begin
            mem_q[wr_idx] <= wr_data;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            rd_data <= 32'h0000_0000;
        else
            rd_data <= mem_q[rd_idx];
    end
endmodule // adc_cfg_regs

// ---- adc_input_and_clock_config.sv ----
`timescale 1ns/1ps

module adc_input_and_clock_config
    import adc_cfg_pkg::*;
(
    // AHB-Lite slave
    input  wire logic                 hclk,
    input  wire logic                 hresetn,
    input  wire logic                 hsel,
    input  wire logic [7:0]           haddr,
    input  wire logic [1:0]           htrans,
    input  wire logic                 hwrite,
    input  wire logic [2:0]           hsize,
    input  wire logic [31:0]          hwdata,
    input  wire logic                 hready,
    output logic      [31:0]          hrdata,
    output logic                      hreadyout,
    output logic                      hresp,
    // Converter core handshake
    input  wire logic                 rc_clk_tick,
    input  wire logic                 sample_start,
    input  wire logic                 conv_done,
    input  wire logic                 irq_event,
    // Analog pin side
    input  wire logic [PIN_W-1:0]     pin_level,
    output logic      [PIN_W-1:0]     pin_out,
    output logic      [PIN_W-1:0]     pin_oe,
    output logic      [PIN_W-1:0]     pin_analog,
    // Analog front end controls
    output logic                      converter_on,
    output logic                      resolution_12,
    output logic                      tad_tick,
    output logic                      converting,
    output adc_cfg_pkg::input_sel_t   cur_input,
    output adc_cfg_pkg::ref_sel_t     ref_sel,
    output logic      [NUM_CH-1:0]    charge_unit_route,
    output logic                      charge_unit_on,
    output logic      [2:0]           internal_source_on
);
    import adc_cfg_pkg::*;

    // ----------------------------------------------------------------
    // Bus slave
    // ----------------------------------------------------------------
    logic        wr_pend_q;
    logic [7:0]  addr_q;
    logic        rd_pend_q;
    logic        mem_rd_q;
    logic [31:0] ctrl_q;
    logic [31:0] refclk_q;
    logic [31:0] mux_q;
    logic [PIN_W-1:0] ansel_q;
    logic [PIN_W-1:0] dir_q;
    logic [PIN_W-1:0] pout_q;
    logic [31:0] mem_rd;
    logic        access;

    function automatic logic is_mem(input logic [7:0] a);
        return (a == SCAN_SEL_OFF) || (a == CTU_EN_OFF);
    endfunction

    function automatic logic [2:0] mem_idx(input logic [7:0] a);
        return (a == CTU_EN_OFF) ? 3'd1 : 3'd0;
    endfunction

    assign access = hsel && hready && htrans[1];

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend_q <= 1'b0;
            rd_pend_q <= 1'b0;
            addr_q    <= 8'h00;
        end
        else
        begin
            if (hready)
            begin
                wr_pend_q <= access && hwrite;
                rd_pend_q <= access && !hwrite;
                if (access)
                    addr_q <= haddr;
            end
        end
    end

    // Reads of the mask store take one extra wait state
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            mem_rd_q <= 1'b0;
        else
            mem_rd_q <= access && !hwrite && is_mem(haddr);
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            hreadyout <= 1'b1;
        else if (access && !hwrite && is_mem(haddr))
            hreadyout <= 1'b0;
        else
            hreadyout <= 1'b1;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            hresp <= 1'b0;
        else
            hresp <= 1'b0;
    end

    adc_cfg_regs u_masks
    (
        .hclk    (hclk),
        .hresetn (hresetn),
        .wr_en   (wr_pend_q && is_mem(addr_q)),
        .wr_idx  (mem_idx(addr_q)),
        .wr_data (hwdata),
        .rd_idx  (rd_pend_q ? mem_idx(addr_q) : mem_idx(haddr)),
        .rd_data (mem_rd)
    );

    // Shadow copies of the masks for the sequencer and charge unit; mask store serves reads
    logic [NUM_CH-1:0] scan_mask_q;
    logic [NUM_CH-1:0] ctu_mask_q;

    // ----------------------------------------------------------------
    // Control registers
    // ----------------------------------------------------------------
    // Disable only gates activity; nothing here is cleared by it
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ctrl_q      <= 32'h0000_0000;
            refclk_q    <= 32'h0000_0000;
            mux_q       <= 32'h0000_0000;
            scan_mask_q <= '0;
            ctu_mask_q  <= '0;
            ansel_q     <= ANSEL_RESET;
            dir_q       <= DIR_RESET;
            pout_q      <= '0;
        end
        else if (wr_pend_q)
        begin
            case (addr_q)
                CTRL_OFF:     ctrl_q      <= hwdata;
                REF_CLK_OFF:  refclk_q    <= hwdata;
                MUX_OFF:      mux_q       <= hwdata;
                SCAN_SEL_OFF: scan_mask_q <= hwdata;
                CTU_EN_OFF:   ctu_mask_q  <= hwdata;
                ANSEL_OFF:    ansel_q     <= hwdata[PIN_W-1:0];
                DIR_OFF:      dir_q       <= hwdata[PIN_W-1:0];
                PIN_OUT_OFF:  pout_q      <= hwdata[PIN_W-1:0];
                default:      ;
            endcase
        end
    end

    logic       enable;
    logic       alt_en;
    logic       scan_en;
    logic [4:0] smpi;
    logic [5:0] prescale;
    logic       use_rc;

    assign enable   = ctrl_q[ENABLE_BIT];
    assign alt_en   = ctrl_q[ALT_BIT];
    assign scan_en  = ctrl_q[SCAN_BIT];
    assign smpi     = ctrl_q[SMPI_LSB +: 5];
    assign prescale = refclk_q[PRESCALE_LSB +: 6];
    assign use_rc   = refclk_q[RC_BIT];

    // ----------------------------------------------------------------
    // Conversion clock
    // ----------------------------------------------------------------
    logic [5:0] div_q;
    logic       tick;

    // RC source ignores the prescale field entirely
    assign tick = use_rc ? rc_clk_tick : (div_q == prescale);

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            div_q <= 6'd0;
        else if (!enable || use_rc || div_q == prescale)
            div_q <= 6'd0;
        else
            div_q <= div_q + 6'd1;
    end

    // ----------------------------------------------------------------
    // Conversion length
    // ----------------------------------------------------------------
    logic [3:0] tad_cnt_q;
    logic       conv_q;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            conv_q    <= 1'b0;
            tad_cnt_q <= 4'd0;
        end
        else if (!enable)
        begin
            conv_q    <= 1'b0;
            tad_cnt_q <= 4'd0;
        end
        else if (!conv_q && sample_start)
        begin
            conv_q    <= 1'b1;
            // 12-bit takes two more periods than 10-bit
            tad_cnt_q <= ctrl_q[RES_BIT] ? TAD_12BIT : TAD_10BIT;
        end
        else if (conv_q && tick)
        begin
            tad_cnt_q <= tad_cnt_q - 4'd1;
            if (tad_cnt_q == 4'd1)
                conv_q <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Input sequencing
    // ----------------------------------------------------------------
    logic       use_b_q;
    logic [4:0] scan_ch_q;
    logic [4:0] scan_cnt_q;
    logic [4:0] next_scan;

    // Next selected channel above the current one; wraps to lowest
    function automatic logic [4:0] next_sel(input logic [NUM_CH-1:0] m,
                                            input logic [4:0] from,
                                            input logic incl);
        logic [4:0] r;
        logic       found;
        r     = 5'd0;
        found = 1'b0;
        for (int i = 0; i < NUM_CH; i++)
        begin
            if (!found && m[i] && (i > from || (incl && i == from)))
            begin
                r     = 5'(i);
                found = 1'b1;
            end
        end
        for (int i = 0; i < NUM_CH; i++)
        begin
            if (!found && m[i])
            begin
                r     = 5'(i);
                found = 1'b1;
            end
        end
        return r;
    endfunction

    assign next_scan = next_sel(scan_mask_q, scan_ch_q, 1'b0);

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            use_b_q    <= 1'b0;
            scan_ch_q  <= 5'd0;
            scan_cnt_q <= 5'd0;
        end
        else if (!enable || irq_event)
        begin
            // Sequence restarts at mux A, lowest channel
            use_b_q    <= 1'b0;
            scan_ch_q  <= next_sel(scan_mask_q, 5'd0, 1'b1);
            scan_cnt_q <= 5'd0;
        end
        else if (conv_done)
        begin
            use_b_q <= alt_en ? !use_b_q : 1'b0;
            // Scan advances only on mux A samples
            if (scan_en && !use_b_q && scan_cnt_q != smpi)
            begin
                scan_ch_q  <= next_scan;
                scan_cnt_q <= scan_cnt_q + 5'd1;
            end
            // Higher channels beyond the per-interrupt count stay idle
        end
    end

    input_sel_t sel_d;

    always_comb
    begin
        sel_d.mux_b = use_b_q;
        if (use_b_q)
        begin
            sel_d.pos = mux_q[B_POS_LSB +: 5];
            sel_d.neg = mux_q[B_NEG_LSB +: 3];
        end
        else
        begin
            sel_d.pos = scan_en ? scan_ch_q : mux_q[A_POS_LSB +: 5];
            sel_d.neg = mux_q[A_NEG_LSB +: 3];
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    logic [PIN_W-1:0] port_view;

    assign port_view = pin_level & ~ansel_q;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            converter_on       <= 1'b0;
            resolution_12      <= 1'b0;
            tad_tick           <= 1'b0;
            converting         <= 1'b0;
            cur_input          <= '0;
            ref_sel            <= '0;
            charge_unit_route  <= '0;
            charge_unit_on     <= 1'b0;
            internal_source_on <= 3'd0;
            pin_out            <= '0;
            pin_oe             <= '0;
            pin_analog         <= ANSEL_RESET;
        end
        else
        begin
            converter_on       <= enable;
            resolution_12      <= ctrl_q[RES_BIT];
            tad_tick           <= enable && tick;
            converting         <= conv_q;
            cur_input          <= sel_d;
            ref_sel.pos_ext     <= refclk_q[PREF_LSB +: 2] == PREF_EXT;
            ref_sel.pos_bandgap <= refclk_q[PREF_LSB +: 2] == PREF_BANDGAP;
            ref_sel.neg_ext     <= refclk_q[NREF_BIT];
            charge_unit_route  <= enable ? ctu_mask_q : '0;
            charge_unit_on     <= enable && (ctu_mask_q != '0);
            internal_source_on <= (enable && scan_en) ? ctrl_q[ISRC_LSB +: 3] : 3'd0;
            pin_out            <= pout_q;
            pin_oe             <= ~dir_q;
            pin_analog         <= ansel_q;
        end
    end

    // Read data
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            hrdata <= 32'h0000_0000;
        else if (mem_rd_q)
            hrdata <= mem_rd;
        else if (access && !hwrite)
        begin
            case (haddr)
                CTRL_OFF:    hrdata <= ctrl_q;
                REF_CLK_OFF: hrdata <= refclk_q;
                MUX_OFF:     hrdata <= mux_q;
                ANSEL_OFF:   hrdata <= {16'h0000, ansel_q};
                DIR_OFF:     hrdata <= {16'h0000, dir_q};
                PORT_OFF:    hrdata <= {16'h0000, port_view};
                STATUS_OFF:  hrdata <= {21'h0, scan_ch_q, use_b_q, conv_q, tad_cnt_q};
                PIN_OUT_OFF: hrdata <= {16'h0000, pout_q};
                default:     hrdata <= UNMAPPED_RD;
            endcase
        end
    end
endmodule // adc_input_and_clock_config

// ---- analog_side_model.sv ----
`timescale 1ns/1ps

// ----------------------------------------
// Converter core and pin side stand-in
// ----------------------------------------
module analog_side_model
(
    // Clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // Bench commands
    input  wire logic        fire,
    input  wire logic        rc_run,
    // Design status
    input  wire logic        converting,
    // Toward the design
    output logic             sample_start,
    output logic             conv_done,
    output logic             rc_clk_tick,
    output logic [15:0]      pin_level
);
    logic [1:0] div_q;
    logic       conv_q;

    // Fixed pin pattern so analog masking shows up in port reads
    assign pin_level = 16'ha5a5;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            sample_start <= 1'b0;
            conv_done    <= 1'b0;
            conv_q       <= 1'b0;
            div_q        <= 2'h0;
            rc_clk_tick  <= 1'b0;
        end
        else
        begin
            sample_start <= fire;
            conv_q       <= converting;
            conv_done    <= conv_q & ~converting;
            // Oscillator only runs while the bench asks for it
            div_q        <= rc_run ? div_q + 2'h1 : 2'h0;
            rc_clk_tick  <= rc_run && (div_q == 2'h3);
        end
    end
endmodule // analog_side_model

// ---- adc_cfg_checker.sv ----
`timescale 1ns/1ps

// ----------------------------------------
// Port-level checks
// ----------------------------------------
module adc_cfg_checker
    import adc_cfg_pkg::*;
(
    input wire logic              hclk,
    input wire logic              hresetn,
    input wire logic              hsel,
    input wire logic [7:0]        haddr,
    input wire logic [1:0]        htrans,
    input wire logic              hwrite,
    input wire logic              hready,
    input wire logic [31:0]       hrdata,
    input wire logic              hreadyout,
    input wire logic              sample_start,
    input wire logic              converter_on,
    input wire logic              resolution_12,
    input wire logic              tad_tick,
    input wire logic              converting,
    input wire logic [PIN_W-1:0]  pin_analog,
    input wire logic [NUM_CH-1:0] charge_unit_route,
    input wire logic              charge_unit_on,
    input wire logic [2:0]        internal_source_on
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    logic [4:0] cnt_q;

    // Ticks seen while converting; cleared between conversions
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            cnt_q <= 5'h0;
        else
            cnt_q <= converting ? cnt_q + {4'h0, tad_tick} : 5'h0;
    end

    sequence port_rd;
        hsel && hready && htrans[1] && !hwrite && haddr == PORT_OFF ##1 hreadyout;
    endsequence

    conv_len_a: assert property ($fell(converting) && converter_on |->
        cnt_q == (resolution_12 ? 5'(TAD_12BIT) : 5'(TAD_10BIT)))
        else $error("conversion length wrong");
    conv_start_a: assert property (sample_start && converter_on && !converting
        |-> ##[1:2] converting) else $error("conversion did not start");
    tad_gate_a: assert property (tad_tick |-> converter_on || $past(converter_on))
        else $error("tad tick while disabled");
    off_idle_a: assert property (!converter_on [*2] |-> !converting)
        else $error("converting while disabled");
    isrc_gate_a: assert property ((|internal_source_on) |->
        converter_on || $past(converter_on)) else $error("source on while disabled");
    ctu_route_a: assert property ((|charge_unit_route) && converter_on
        |-> ##[0:1] charge_unit_on) else $error("charge unit not enabled");
    port_zero_a: assert property (port_rd |-> (hrdata[PIN_W-1:0] & pin_analog) == '0)
        else $error("analog pin read nonzero");
    analog_rst_a: assert property ($rose(hresetn) |-> pin_analog == '1)
        else $error("pins not analog after reset");
endmodule // adc_cfg_checker

bind adc_input_and_clock_config adc_cfg_checker chk (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .sample_start(sample_start), .converter_on(converter_on),
    .resolution_12(resolution_12), .tad_tick(tad_tick), .converting(converting),
    .pin_analog(pin_analog), .charge_unit_route(charge_unit_route),
    .charge_unit_on(charge_unit_on), .internal_source_on(internal_source_on));

// ---- adc_input_and_clock_config_bench.sv ----
`timescale 1ns/1ps

`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin err_total++; \
    $display("ERROR %0t: got %h want %h", $time, (a), (b)); end end

module adc_input_and_clock_config_bench;
    import adc_cfg_pkg::*;

    logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
    logic [7:0]  haddr;
    logic [1:0]  htrans;
    logic [2:0]  hsize, internal_source_on;
    logic [31:0] hwdata, hrdata, rdat, charge_unit_route;
    logic        rc_clk_tick, sample_start, conv_done, irq_event, fire, rc_run;
    logic [15:0] pin_level, pin_out, pin_oe, pin_analog;
    logic        converter_on, resolution_12, tad_tick, converting, charge_unit_on;
    input_sel_t  cur_input;
    ref_sel_t    ref_sel;
    int          err_total, n_checks, cyc_cnt, n;

    adc_input_and_clock_config DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .rc_clk_tick(rc_clk_tick), .sample_start(sample_start), .conv_done(conv_done),
        .irq_event(irq_event), .pin_level(pin_level), .pin_out(pin_out), .pin_oe(pin_oe),
        .pin_analog(pin_analog), .converter_on(converter_on), .resolution_12(resolution_12),
        .tad_tick(tad_tick), .converting(converting), .cur_input(cur_input),
        .ref_sel(ref_sel), .charge_unit_route(charge_unit_route),
        .charge_unit_on(charge_unit_on), .internal_source_on(internal_source_on));

    analog_side_model far (.hclk(hclk), .hresetn(hresetn), .fire(fire), .rc_run(rc_run),
        .converting(converting), .sample_start(sample_start), .conv_done(conv_done),
        .rc_clk_tick(rc_clk_tick), .pin_level(pin_level));

    assign hready = hreadyout;

    // ----------------------------------------
    // Clock, timeout, verdict
    // ----------------------------------------
    initial
    begin
        hclk = 1'b0;
        forever #50 hclk = ~hclk;
    end

    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    always @(posedge hclk)
    begin
        cyc_cnt++;
        if (cyc_cnt == 6000)
        begin
            err_total++;
            final_report();
        end
    end

    // ----------------------------------------
    // Bus and stimulus helpers
    // ----------------------------------------
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
        @(posedge hclk);
        hsel <= 1'b1; htrans <= 2'b10; haddr <= a; hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0; htrans <= 2'b00; hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rdat = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        `CHK(rdat, e)
        `CHK(hresp, 1'b0)
    endtask

    task automatic cyc(input int k);
        repeat (k) @(posedge hclk);
    endtask

    // Setup only while disabled, enable written last, then settle
    task automatic cfg(input logic [31:0] ctrl);
        wr(CTRL_OFF, 32'h0);
        wr(CTRL_OFF, ctrl);
        cyc(4);
    endtask

    task automatic conv();
        @(posedge hclk) fire <= 1'b1;
        @(posedge hclk) fire <= 1'b0;
        while (converting !== 1'b1) @(posedge hclk);
        n = 0;
        while (converting === 1'b1)
        begin
            if (tad_tick === 1'b1) n++;
            @(posedge hclk);
        end
        cyc(3);
    endtask

    task automatic gap();
        while (tad_tick !== 1'b1) @(posedge hclk);
        n = 0;
        do begin @(posedge hclk); n++; end while (tad_tick !== 1'b1);
    endtask

    task automatic irq();
        @(posedge hclk) irq_event <= 1'b1;
        @(posedge hclk) irq_event <= 1'b0;
        cyc(2);
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_pins();
        `CHK(pin_analog, 16'hffff)
        `CHK(pin_oe, 16'h0000)
        rd(ANSEL_OFF, 32'hffff);
        rd(DIR_OFF, 32'hffff);
        wr(ANSEL_OFF, 32'h00ff);
        wr(DIR_OFF, 32'h0f0f);
        wr(PIN_OUT_OFF, 32'h1234);
        cyc(2);
        `CHK(pin_analog, 16'h00ff)
        `CHK(pin_oe, 16'hf0f0)
        `CHK(pin_out, 16'h1234)
        rd(PORT_OFF, 32'ha500);
        rd(8'h3c, UNMAPPED_RD);
        $display("pins test done");
    endtask

    task automatic t_refs();
        for (int i = 0; i < 3; i++)
            for (int k = 0; k < 2; k++)
            begin
                wr(REF_CLK_OFF, 32'(i) | 32'(k << NREF_BIT));
                cyc(2);
                `CHK(ref_sel, {i == 1, i == 2, k == 1})
            end
        $display("refs test done");
    endtask

    task automatic t_clock();
        wr(REF_CLK_OFF, 32'h0200);
        cfg(32'h88);
        `CHK(resolution_12, 1'b1)
        gap();
        `CHK(n, 3)
        conv();
        `CHK(n, 32'(TAD_12BIT))
        cfg(32'h80);
        `CHK(resolution_12, 1'b0)
        conv();
        `CHK(n, 32'(TAD_10BIT))
        wr(CTRL_OFF, 32'h0);
        wr(REF_CLK_OFF, 32'h8500);
        rc_run <= 1'b1;
        cfg(32'h80);
        gap();
        `CHK(n, 4)
        conv();
        `CHK(n, 32'(TAD_10BIT))
        rc_run <= 1'b0;
        wr(CTRL_OFF, 32'h0);
        wr(REF_CLK_OFF, 32'h0000);
        $display("clock test done");
    endtask

    task automatic t_mux();
        wr(CTRL_OFF, 32'h0);
        wr(MUX_OFF, 32'h4723);
        cfg(32'h80);
        conv();
        conv();
        `CHK(cur_input, {5'd3, 3'd1, 1'b0})
        cfg(32'h81);
        `CHK(cur_input, {5'd3, 3'd1, 1'b0})
        conv();
        `CHK(cur_input, {5'd7, 3'd2, 1'b1})
        conv();
        `CHK(cur_input, {5'd3, 3'd1, 1'b0})
        $display("mux test done");
    endtask

    task automatic t_scan();
        wr(CTRL_OFF, 32'h0);
        wr(SCAN_SEL_OFF, 32'h124);
        cfg(32'h182);
        `CHK(cur_input, {5'd2, 3'd1, 1'b0})
        conv();
        `CHK(cur_input, {5'd5, 3'd1, 1'b0})
        conv();
        `CHK(cur_input.pos == 5'd8, 1'b0)
        irq();
        `CHK(cur_input, {5'd2, 3'd1, 1'b0})
        cfg(32'h183);
        conv();
        `CHK(cur_input, {5'd7, 3'd2, 1'b1})
        conv();
        `CHK(cur_input, {5'd5, 3'd1, 1'b0})
        $display("scan test done");
    endtask

    task automatic t_units();
        wr(CTRL_OFF, 32'h0);
        wr(CTU_EN_OFF, 32'h10);
        cfg(32'h5_0182);
        `CHK(charge_unit_route, 32'h10)
        `CHK(charge_unit_on, 1'b1)
        `CHK(internal_source_on, 3'b101)
        rd(CTU_EN_OFF, 32'h10);
        wr(CTRL_OFF, 32'h0);
        cyc(2);
        `CHK(converter_on, 1'b0)
        rd(MUX_OFF, 32'h4723);
        rd(SCAN_SEL_OFF, 32'h124);
        rd(STATUS_OFF, 32'h80);
        $display("units test done");
    endtask

    initial
    begin
        hresetn = 1'b0; hsel = 1'b0; haddr = 8'h00; htrans = 2'b00; hwrite = 1'b0;
        hsize = 3'h2; hwdata = 32'h0; irq_event = 1'b0; fire = 1'b0; rc_run = 1'b0;
        err_total = 0; n_checks = 0; cyc_cnt = 0;
        cyc(20);
        hresetn <= 1'b1;
        t_pins();
        t_refs();
        t_clock();
        t_mux();
        t_scan();
        t_units();
        final_report();
    end
endmodule // adc_input_and_clock_config_bench
